// *** hw/drf_defines.vh ***
`ifndef DRF_DEFINES_VH
`define DRF_DEFINES_VH
// Register map (byte addresses)
`define DRF_OFF_MODE 12'h000
`define DRF_OFF_ARITH_STATUS_FLAGS 12'h004
`define DRF_OFF_STICKY_STATUS_FLAGS 12'h008
`define DRF_OFF_IMASK 12'h00c
`define DRF_OFF_FPIN 12'h010
`define DRF_OFF_FPOUT 12'h014
`define DRF_OFF_CMD 12'h018
`define DRF_OFF_RSEL 12'h01c
`define DRF_OFF_RDATA 12'h020
`define DRF_OFF_RDLOW 12'h024
// Mode control word fields
`define DRF_MODE_UPPER_ALT 7
`define DRF_MODE_LOWER_ALT 10
`define DRF_MODE_TRUNC 15
`define DRF_MODE_ROUND_BOUNDARY_SELECT 16
`define DRF_MODE_RST 32'h00000000
// Status flag fields
`define DRF_FLG_UNF 0
`define DRF_FLG_OVF 1
`define DRF_FLG_INV 2
// Command codes
`define DRF_CMD_NONE 3'h0
`define DRF_CMD_PACK 3'h1
`define DRF_CMD_UNPACK 3'h2
`define DRF_CMD_ROUND 3'h3
`define DRF_QNAN 40'hffffffffff
`endif

// *** hw/drf_regfile.v ***
// Functional notes
// - Sixteen primary and sixteen alternate registers, each forty bits wide.
// - Fixed-point values sit in upper 32 bits; low eight read ignored, written zero.
// - Data-memory bus transfers carry all forty register bits.
// - Program-memory bus uses its top forty bits; low eight driven zero.
// - One program-memory and one data-memory access may occur per cycle.
// - Same-cycle read returns old value; new value stored at cycle end.
// - Write priority: data memory, bus RDATA write, program memory, ALU, multiplier, shifter.
// - Lower and upper halves switch banks independently, each by own bit.
// - Unit results are usable by any unit the next cycle.
// - Round-boundary bit selects 40-bit extended or 32-bit single float.
// - In 32-bit mode zero input low byte, round to 23 bits, zero result low byte.
// - Short float: sign, 4-bit exponent, 11-bit mantissa in low sixteen bits.
// - Pack/unpack in one cycle; underflowing pack forms denormal with exponent zero.
// - NaN input raises invalid and returns all-ones quiet NaN.
// - Denormal inputs are treated as zero without underflow.
// - Denormal or underflowing round results become zero and raise underflow.
// - Only nearest and toward-zero rounding; no inexact flag.
// - Toward-zero rounding truncates.
// - Nearest rounding goes to nearer value; ties go to even.
// - Halfway between largest finite and infinity rounds to infinity.
// - Overflow, underflow, invalid update status and sticky flags and raise maskable interrupt.
// - Units read fixed operands ignoring low eight bits, write zero-filled.
// - Upper-half alternate select is mode bit 7, lower-half bit 10.
// - New bank becomes accessible one cycle after the select bit changes.
`timescale 1ns/1ns
`default_nettype none
`include "drf_defines.vh"
module drf_regfile (
  // AHB-Lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Read ports for the computation units
  input wire [3:0] x_addr,
  input wire [3:0] y_addr,
  output reg [39:0] x_data,
  output reg [39:0] y_data,
  // Data-memory data bus
  input wire dm_wr,
  input wire dm_rd,
  input wire [3:0] dm_addr,
  input wire [39:0] dm_wdata,
  output reg [39:0] dm_rdata,
  // Program-memory data bus (48 bits)
  input wire pm_wr,
  input wire pm_rd,
  input wire [3:0] pm_addr,
  input wire [47:0] pm_wdata,
  output reg [47:0] pm_rdata,
  // Unit result write ports
  input wire alu_wr,
  input wire alu_fixed,
  input wire [3:0] alu_addr,
  input wire [39:0] alu_wdata,
  input wire mul_wr,
  input wire mul_fixed,
  input wire [3:0] mul_addr,
  input wire [39:0] mul_wdata,
  input wire sh_wr,
  input wire sh_fixed,
  input wire [3:0] sh_addr,
  input wire [39:0] sh_wdata,
  // Floating-point exception events from ALU and multiplier
  input wire [2:0] alu_fexc,
  input wire [2:0] mul_fexc,
  // Mode and interrupt
  output reg upper_half_alt_select,
  output reg lower_half_alt_select,
  output reg round_boundary_select,
  output reg trunc_mode,
  output reg fp_irq
);
  reg [39:0] bank_r [0:31];
  reg [31:0] mode_control_word_r;
  reg [2:0] arith_status_flags_r;
  reg [2:0] sticky_status_flags_r;
  reg [2:0] imask_r;
  reg [39:0] fpin_r;
  reg [39:0] fpout_r;
  reg [3:0] rsel_r;
  reg [2:0] fp_exc_r;
  reg fp_exc_vld_r;
  reg [39:0] cpu_wdata_r;
  reg cpu_wr_r;
  reg [7:0] cpu_hi_r;
  reg ap_wr_r;
  reg ap_rd_r;
  reg [11:0] ap_addr_r;
  reg [31:0] rdata_nxt;

  // Physical index: bank select applies one cycle after the mode write
  function [4:0] phys;
    input [3:0] a;
    begin
      if (a[3])
        phys = {upper_half_alt_select, a};
      else
        phys = {lower_half_alt_select, a};
    end
  endfunction

  function [39:0] fixz;
    input fx;
    input [39:0] d;
    begin
      fixz = fx ? {d[39:8], 8'h00} : d;
    end
  endfunction

  // Read ports are combinational from stored state: old value seen this cycle
  always @*
  begin
    x_data = bank_r[phys(x_addr)];
    y_data = bank_r[phys(y_addr)];
    dm_rdata = dm_rd ? bank_r[phys(dm_addr)] : 40'h0000000000;
    pm_rdata = pm_rd ? {bank_r[phys(pm_addr)], 8'h00} : 48'h000000000000;
  end

  // Write arbitration per register, data memory first
  wire [15:0] we_v;
  wire [639:0] wv_v;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_reg
      localparam [3:0] idx = gi;
      reg [39:0] wv;
      reg we;
      always @*
      begin
        we = 1'b1;
        if (dm_wr && dm_addr == idx)
          wv = dm_wdata;
        else if (cpu_wr_r && rsel_r == idx)
          wv = cpu_wdata_r;
        else if (pm_wr && pm_addr == idx)
          wv = {pm_wdata[47:8]};
        else if (alu_wr && alu_addr == idx)
          wv = fixz(alu_fixed, alu_wdata);
        else if (mul_wr && mul_addr == idx)
          wv = fixz(mul_fixed, mul_wdata);
        else if (sh_wr && sh_addr == idx)
          wv = fixz(sh_fixed, sh_wdata);
        else
        begin
          we = 1'b0;
          wv = 40'h0000000000;
        end
      end
      assign we_v[gi] = we;
      assign wv_v[gi * 40 +: 40] = wv;
    end
  endgenerate

  // One process owns the array so no entry has two drivers
  integer wi;
  always @(posedge hclk)
  begin
    for (wi = 0; wi < 16; wi = wi + 1)
      if (we_v[wi])
        bank_r[phys(wi[3:0])] <= wv_v[wi * 40 +: 40];
  end

  // Float helpers
  function [39:0] fp_in;
    input [39:0] d;
    input r32;
    reg [39:0] t;
    begin
      t = r32 ? {d[39:8], 8'h00} : d;
      if (t[38:31] == 8'h00)
        fp_in = {t[39], 39'h0};
      else
        fp_in = t;
    end
  endfunction

  // Round 40-bit extended value to 32-bit boundary
  function [40:0] fp_round;
    input [39:0] d;
    input tr;
    reg [32:0] s;
    reg up;
    begin
      up = ~tr & d[7] & ((|d[6:0]) | d[8]);
      s = {1'b0, d[39:8]} + {32'h0, up};
      // Carry into exponent field 0xff gives infinity
      fp_round = {(s[30:23] == 8'hff), s[31:0], 8'h00};
    end
  endfunction

  // Single to short float
  function [18:0] fp_pack;
    input [31:0] f;
    reg [7:0] e;
    reg [11:0] m;
    reg [4:0] sh;
    reg [7:0] dlt;
    reg [11:0] t12;
    begin
      e = f[30:23];
      m = {1'b1, f[22:12]};
      fp_pack = {3'b000, f[31], 15'h0};
      if (e > 8'h86)
        fp_pack = {3'b010, f[31], 4'hf, 11'h7ff};
      else if (e >= 8'h79)
        fp_pack = {3'b000, f[31], e[3:0] - 4'h8, f[22:12]};
      else if (e >= 8'h6e)
      begin
        dlt = 8'h79 - e;
        sh = dlt[4:0];
        t12 = m >> sh;
        fp_pack = {3'b000, f[31], 4'h0, t12[10:0]};
      end
    end
  endfunction

  function [31:0] fp_unpack;
    input [15:0] h;
    reg [3:0] k;
    reg [10:0] m;
    begin
      fp_unpack = {h[15], 31'h0};
      if (h[14:11] != 4'h0)
        fp_unpack = {h[15], 8'h78 + {4'h0, h[14:11]}, h[10:0], 12'h000};
      else
        for (k = 4'd11; k != 4'd0; k = k - 4'd1)
          if (h[k - 1] && fp_unpack[30:0] == 31'h0)
          begin
            m = h[10:0] << (4'd12 - k);
            fp_unpack = {h[15], 8'h6d + {4'h0, k}, m, 12'h000};
          end
    end
  endfunction

  // Flag and interrupt update, sticky set wins over clear
  wire [2:0] ev = alu_fexc | mul_fexc | (fp_exc_vld_r ? fp_exc_r : 3'h0);
  wire ap_take = hsel & hready & htrans[1];
  wire [39:0] opi = fp_in(fpin_r, round_boundary_select);
  wire [40:0] rnd = fp_round(opi, trunc_mode);
  wire [18:0] pk = fp_pack(opi[39:8]);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_control_word_r <= `DRF_MODE_RST;
      upper_half_alt_select <= 1'b0;
      lower_half_alt_select <= 1'b0;
      round_boundary_select <= 1'b0;
      trunc_mode <= 1'b0;
      arith_status_flags_r <= 3'h0;
      sticky_status_flags_r <= 3'h0;
      imask_r <= 3'h0;
      fp_irq <= 1'b0;
      fpin_r <= 40'h0;
      fpout_r <= 40'h0;
      rsel_r <= 4'h0;
      fp_exc_r <= 3'h0;
      fp_exc_vld_r <= 1'b0;
      cpu_wdata_r <= 40'h0;
      cpu_wr_r <= 1'b0;
      cpu_hi_r <= 8'h0;
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_addr_r <= 12'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      hreadyout <= 1'b1;
      ap_wr_r <= ap_take & hwrite;
      ap_rd_r <= ap_take & ~hwrite;
      ap_addr_r <= haddr;
      cpu_wr_r <= 1'b0;
      fp_exc_vld_r <= 1'b0;
      upper_half_alt_select <= mode_control_word_r[`DRF_MODE_UPPER_ALT];
      lower_half_alt_select <= mode_control_word_r[`DRF_MODE_LOWER_ALT];
      round_boundary_select <= mode_control_word_r[`DRF_MODE_ROUND_BOUNDARY_SELECT];
      trunc_mode <= mode_control_word_r[`DRF_MODE_TRUNC];
      if (ap_take && !hwrite)
        hrdata <= rdata_nxt;
      if (|ev)
        arith_status_flags_r <= ev;
      sticky_status_flags_r <= sticky_status_flags_r | ev;
      if (ap_wr_r)
      begin
        case (ap_addr_r)
          `DRF_OFF_MODE: mode_control_word_r <= hwdata;
          `DRF_OFF_ARITH_STATUS_FLAGS: arith_status_flags_r <= hwdata[2:0] | ev;
          `DRF_OFF_STICKY_STATUS_FLAGS: sticky_status_flags_r <= (sticky_status_flags_r & hwdata[2:0]) | ev;
          `DRF_OFF_IMASK: imask_r <= hwdata[2:0];
          // Low byte from the staging register, so rounding sees guard bits
          `DRF_OFF_FPIN: fpin_r <= {hwdata, cpu_hi_r};
          `DRF_OFF_RSEL: rsel_r <= hwdata[3:0];
          `DRF_OFF_RDLOW: cpu_hi_r <= hwdata[7:0];
          `DRF_OFF_RDATA:
          begin
            cpu_wdata_r <= {hwdata, cpu_hi_r};
            cpu_wr_r <= 1'b1;
          end
          `DRF_OFF_CMD:
          begin
            fp_exc_vld_r <= 1'b1;
            fp_exc_r <= 3'h0;
            if (opi[38:31] == 8'hff && opi[30:0] != 31'h0)
            begin
              fpout_r <= `DRF_QNAN;
              fp_exc_r[`DRF_FLG_INV] <= 1'b1;
            end
            else
            begin
              case (hwdata[2:0])
                `DRF_CMD_PACK:
                begin
                  fpout_r <= {16'h0, pk[15:0], 8'h00};
                  fp_exc_r[`DRF_FLG_OVF] <= pk[17];
                end
                `DRF_CMD_UNPACK: fpout_r <= {fp_unpack(fpin_r[23:8]), 8'h00};
                `DRF_CMD_ROUND:
                begin
                  if (rnd[38:31] == 8'h00 && rnd[30:0] != 31'h0)
                  begin
                    fpout_r <= {rnd[39], 39'h0};
                    fp_exc_r[`DRF_FLG_UNF] <= 1'b1;
                  end
                  else
                  begin
                    fpout_r <= rnd[39:0];
                    fp_exc_r[`DRF_FLG_OVF] <= rnd[40];
                  end
                end
                default: fpout_r <= opi;
              endcase
            end
          end
          default: ;
        endcase
      end
      fp_irq <= |((sticky_status_flags_r | ev) & imask_r);
    end
  end

  always @*
  begin
    case (haddr)
      `DRF_OFF_MODE: rdata_nxt = mode_control_word_r;
      `DRF_OFF_ARITH_STATUS_FLAGS: rdata_nxt = {29'h0, arith_status_flags_r};
      `DRF_OFF_STICKY_STATUS_FLAGS: rdata_nxt = {29'h0, sticky_status_flags_r};
      `DRF_OFF_IMASK: rdata_nxt = {29'h0, imask_r};
      `DRF_OFF_FPIN: rdata_nxt = fpin_r[39:8];
      `DRF_OFF_FPOUT: rdata_nxt = fpout_r[39:8];
      `DRF_OFF_RSEL: rdata_nxt = {28'h0, rsel_r};
      `DRF_OFF_RDATA: rdata_nxt = bank_r[phys(rsel_r)][39:8];
      `DRF_OFF_RDLOW: rdata_nxt = {24'h0, bank_r[phys(rsel_r)][7:0]};
      default: rdata_nxt = 32'h0;
    endcase
  end
endmodule
`default_nettype wire

// *** tb/drf_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module drf_mem_model (
  // Clock
  input wire logic hclk,
  // Data-memory bus
  input wire logic dm_wr,
  input wire logic dm_rd,
  input wire logic [39:0] dm_rdata,
  output logic [39:0] dm_wdata
);
  logic [39:0] word_r = 40'h5a5a5a5aa5;
  // Stores keep all forty bits and fetches hand them back whole
  always @(posedge hclk)
    if (dm_rd)
      word_r <= dm_rdata;
  // Outside a fetch the bus shows junk, never the last word
  assign dm_wdata = dm_wr ? word_r : ~word_r;
endmodule
`default_nettype wire

// *** tb/drf_regfile_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module drf_regfile_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Memory buses
  input wire logic dm_wr,
  input wire logic dm_rd,
  input wire logic [3:0] dm_addr,
  input wire logic [39:0] dm_wdata,
  input wire logic [39:0] dm_rdata,
  input wire logic pm_wr,
  input wire logic pm_rd,
  input wire logic [47:0] pm_rdata,
  // Units
  input wire logic alu_wr,
  input wire logic alu_fixed,
  input wire logic [3:0] alu_addr,
  input wire logic mul_wr,
  input wire logic sh_wr,
  input wire logic [3:0] x_addr,
  input wire logic [3:0] y_addr,
  input wire logic [39:0] x_data,
  input wire logic [39:0] y_data,
  // Bank selects
  input wire logic upper_half_alt_select,
  input wire logic lower_half_alt_select
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire quiet = !(dm_wr | pm_wr | alu_wr | mul_wr | sh_wr);
  // Same read slot and same banks in the following cycle
  sequence s_keep;
    $stable(x_addr) && $stable({upper_half_alt_select, lower_half_alt_select});
  endsequence
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_pm_pad: assert property (pm_rdata[7:0] == 8'h00)
    else $error("program bus low byte not zero");
  a_pm_idle: assert property (!pm_rd |-> pm_rdata == 48'h0)
    else $error("program bus driven while idle");
  a_dm_idle: assert property (!dm_rd |-> dm_rdata == 40'h0)
    else $error("data bus driven while idle");
  a_dm_full: assert property ((dm_wr && x_addr == dm_addr) ##1 s_keep |-> x_data == $past(dm_wdata))
    else $error("data bus write not stored whole");
  a_old_read: assert property (quiet ##1 (dm_wr && x_addr == dm_addr) ##0 s_keep |-> $stable(x_data))
    else $error("operand read not old value");
  a_fixed_pad: assert property ((alu_wr && alu_fixed && !dm_wr && !pm_wr && x_addr == alu_addr) ##1 s_keep
    |-> x_data[7:0] == 8'h00) else $error("fixed result low byte not zero");
  a_sel_reset: assert property ($rose(hresetn) |-> !upper_half_alt_select && !lower_half_alt_select)
    else $error("alternate bank active after reset");
  a_xy_same: assert property (x_addr == y_addr |-> x_data == y_data)
    else $error("operand ports disagree");
endmodule
bind drf_regfile drf_regfile_checker chk (.hclk, .hresetn, .hreadyout, .hresp, .dm_wr, .dm_rd, .dm_addr,
  .dm_wdata, .dm_rdata, .pm_wr, .pm_rd, .pm_rdata, .alu_wr, .alu_fixed, .alu_addr, .mul_wr, .sh_wr, .x_addr,
  .y_addr, .x_data, .y_data, .upper_half_alt_select, .lower_half_alt_select);
`default_nettype wire

// *** tb/dsp_register_file_and_formats_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "drf_defines.vh"
module dsp_register_file_and_formats_tb;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, alu_fexc = 3'h0, mul_fexc = 3'h0;
  logic [11:0] haddr = 12'h0;
  logic [31:0] hwdata = 32'h0, r;
  logic [3:0] x_addr = 4'h3, y_addr = 4'h3, dm_addr = 4'h3, pm_addr = 4'h3, alu_addr = 4'h3, mul_addr = 4'h3;
  logic [3:0] sh_addr = 4'h3;
  logic dm_wr = 1'h0, dm_rd = 1'h0, pm_wr = 1'h0, pm_rd = 1'h1, alu_wr = 1'h0, mul_wr = 1'h0, sh_wr = 1'h0;
  logic alu_fixed = 1'h1, mul_fixed = 1'h0, sh_fixed = 1'h0;
  logic [47:0] pm_wdata = 48'hb1b2b3b4b5c6;
  logic [39:0] alu_wdata = 40'hc1c2c3c4c5, mul_wdata = 40'hd1d2d3d4d5, sh_wdata = 40'he1e2e3e4e5;
  wire logic [31:0] hrdata;
  wire logic [39:0] x_data, y_data, dm_rdata, dm_wdata;
  wire logic [47:0] pm_rdata;
  wire logic hreadyout, hresp, upper_half_alt_select, lower_half_alt_select, round_boundary_select;
  wire logic trunc_mode, fp_irq;
  int n_fail = 0, comparisons = 0;
  localparam logic [39:0] exp_tab [5] = '{40'h5a5a5a5aa5, 40'hb1b2b3b4b5, 40'hc1c2c3c400, 40'hd1d2d3d4d5,
    40'he1e2e3e4e5};
  drf_regfile dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .x_addr, .y_addr, .x_data, .y_data, .dm_wr, .dm_rd, .dm_addr, .dm_wdata,
    .dm_rdata, .pm_wr, .pm_rd, .pm_addr, .pm_wdata, .pm_rdata, .alu_wr, .alu_fixed, .alu_addr, .alu_wdata,
    .mul_wr, .mul_fixed, .mul_addr, .mul_wdata, .sh_wr, .sh_fixed, .sh_addr, .sh_wdata, .alu_fexc, .mul_fexc,
    .upper_half_alt_select, .lower_half_alt_select, .round_boundary_select, .trunc_mode, .fp_irq);
  drf_mem_model mem (.hclk, .dm_wr, .dm_rd, .dm_rdata, .dm_wdata);
  always #25 hclk = ~hclk;
  task final_report;
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task wr(input logic [3:0] a, input logic [39:0] d);
    @(posedge hclk);
    sh_wr <= 1'h1;
    sh_addr <= a;
    sh_wdata <= d;
    x_addr <= a;
    @(posedge hclk);
    sh_wr <= 1'h0;
    #1;
    chk(x_data, d);
  endtask
  // All five writers aim at one register; one more joins each pass
  task t_prec;
    for (int k = 4; k >= 0; k--)
    begin
      @(posedge hclk);
      dm_wr <= (k < 1);
      pm_wr <= (k < 2);
      alu_wr <= (k < 3);
      mul_wr <= (k < 4);
      sh_wr <= 1'h1;
      #1;
      if (k < 4)
        chk(x_data, exp_tab[k + 1]);
      @(posedge hclk);
      {dm_wr, pm_wr, alu_wr, mul_wr, sh_wr} <= 5'h0;
      dm_rd <= (k == 0);
      #1;
      chk(x_data, exp_tab[k]);
    end
    chk(pm_rdata, {exp_tab[0], 8'h00});
    chk(dm_rdata, exp_tab[0]);
    @(posedge hclk);
    dm_rd <= 1'h0;
  endtask
  task t_bank;
    wr(4'h2, 40'h1122334455);
    ahb(1'h1, `DRF_OFF_MODE, 32'h400, r);
    #1;
    chk(lower_half_alt_select, 1'h0);
    @(posedge hclk);
    #1;
    chk({upper_half_alt_select, lower_half_alt_select}, 2'h1);
    wr(4'h2, 40'h66778899aa);
    ahb(1'h1, `DRF_OFF_MODE, 32'h18080, r);
    @(posedge hclk);
    #1;
    chk(x_data, 40'h1122334455);
    chk({round_boundary_select, trunc_mode, upper_half_alt_select, lower_half_alt_select}, 4'he);
    ahb(1'h1, `DRF_OFF_MODE, 32'h0, r);
  endtask
  task t_exc;
    ahb(1'h1, `DRF_OFF_IMASK, 32'h4, r);
    @(posedge hclk);
    alu_fexc <= 3'h4;
    mul_fexc <= 3'h1;
    @(posedge hclk);
    alu_fexc <= 3'h0;
    mul_fexc <= 3'h0;
    ahb(1'h0, `DRF_OFF_STICKY_STATUS_FLAGS, 32'h0, r);
    chk(r, 32'h5);
    chk(fp_irq, 1'h1);
    ahb(1'h1, `DRF_OFF_STICKY_STATUS_FLAGS, 32'h0, r);
    repeat (2) @(posedge hclk);
    #1;
    chk(fp_irq, 1'h0);
  endtask
  task t_float;
    ahb(1'h1, `DRF_OFF_FPIN, 32'h7fc00001, r);
    ahb(1'h1, `DRF_OFF_CMD, {29'h0, `DRF_CMD_ROUND}, r);
    ahb(1'h0, `DRF_OFF_FPOUT, 32'h0, r);
    chk(r, 32'hffffffff);
    ahb(1'h0, `DRF_OFF_ARITH_STATUS_FLAGS, 32'h0, r);
    chk(r[2], 1'h1);
    ahb(1'h1, 12'h3fc, 32'hffffffff, r);
    ahb(1'h0, 12'h3fc, 32'h0, r);
    chk(r, 32'h0);
  endtask
  task fpop(input logic [31:0] v, input logic [2:0] c);
    ahb(1'h1, `DRF_OFF_FPIN, v, r);
    ahb(1'h1, `DRF_OFF_CMD, {29'h0, c}, r);
    ahb(1'h0, `DRF_OFF_FPOUT, 32'h0, r);
  endtask
  // Low byte 0x80 puts every rounding exactly on a halfway point
  task t_fmt;
    ahb(1'h1, `DRF_OFF_RDLOW, 32'h80, r);
    fpop(32'h3f800001, `DRF_CMD_ROUND);
    chk(r, 32'h3f800002);
    fpop(32'h3f800004, `DRF_CMD_ROUND);
    chk(r, 32'h3f800004);
    fpop(32'h7f7fffff, `DRF_CMD_ROUND);
    chk(r, 32'h7f800000);
    ahb(1'h0, `DRF_OFF_ARITH_STATUS_FLAGS, 32'h0, r);
    chk(r, 32'h2);
    ahb(1'h1, `DRF_OFF_MODE, 32'h8000, r);
    fpop(32'h3f800001, `DRF_CMD_ROUND);
    chk(r, 32'h3f800001);
    ahb(1'h1, `DRF_OFF_MODE, 32'h0, r);
    ahb(1'h1, `DRF_OFF_RDLOW, 32'h0, r);
    fpop(32'h3f800000, `DRF_CMD_PACK);
    chk(r, 32'h3800);
    fpop(32'h3800, `DRF_CMD_UNPACK);
    chk(r, 32'h3f800000);
    fpop(32'h3c000000, `DRF_CMD_PACK);
    chk(r, 32'h400);
    fpop(32'h400, `DRF_CMD_UNPACK);
    chk(r, 32'h3c000000);
  endtask
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    #1;
    chk({upper_half_alt_select, lower_half_alt_select, fp_irq, hreadyout}, 4'h1);
    t_prec();
    t_bank();
    t_exc();
    t_float();
    t_fmt();
    final_report();
  end
  initial
  begin
    repeat (3000) @(posedge hclk);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
